// file: include/umss_pkg.sv
/*
 * Package of the modem-status and scratch register block: bus addresses,
 * field positions, reset values and the packed carriers shared by ports.
 * Assumes a 32-bit Avalon-MM byte address space and one peripheral clock.
 */
package umss_pkg;
    // register byte addresses
    localparam logic [31:0] MODEM_CONTROL_ADDR = 32'h50001010;
    localparam logic [31:0] MODEM_STATUS_ADDR = 32'h50001018;
    localparam logic [31:0] SPARE_STORAGE_ADDR = 32'h5000101C;
    localparam logic [31:0] INT_STATUS_ADDR = 32'h50001040;
    localparam logic [31:0] INT_CLEAR_ADDR = 32'h50001044;
    localparam logic [31:0] INT_ENABLE_ADDR = 32'h50001048;

    // modem_status field positions
    localparam int MS_CARRIER_BIT = 7;
    localparam int MS_RING_BIT = 6;
    localparam int MS_CTS_BIT = 4;
    localparam int MS_CARRIER_CHG_BIT = 3;
    localparam int MS_TERI_BIT = 2;
    localparam int MS_CTS_CHG_BIT = 0;

    // modem_control_register field positions
    localparam int MC_RTS_BIT = 1;
    localparam int MC_AUX_OUTPUT_ONE_BIT = 2;
    localparam int MC_AUX_OUTPUT_TWO_BIT = 3;
    localparam int MC_LOOP_BIT = 4;

    // event index in 3-bit vectors and interrupt registers
    localparam int EV_CTS = 0;
    localparam int EV_RING = 1;
    localparam int EV_CARRIER = 2;

    // reset values
    localparam logic [2:0] PIN_RESET = 3'h7;
    localparam logic [2:0] LEVEL_RESET = 3'h0;
    localparam logic [2:0] FLAG_RESET = 3'h0;
    localparam logic [2:0] INT_RESET = 3'h0;
    localparam logic [7:0] SPARE_RESET = 8'h00;
    localparam logic MC_BIT_RESET = 1'b0;
    localparam logic [31:0] READ_RESET = 32'h00000000;

    typedef struct packed {
        logic read;
        logic write;
        logic [31:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } umss_av_req_t;

    // active-low modem lines, ordered as the event index
    typedef struct packed {
        logic carrier_low;
        logic ring_in_low;
        logic cts_low;
    } umss_modem_in_t;

    typedef struct packed {
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] sync3;
        logic [2:0] filt;
        logic [2:0] prev;
        logic [2:0] flag;
        logic loopback;
        logic aux_output_two;
        logic aux_output_one;
        logic rts;
        logic [7:0] spare_storage_field;
        logic [2:0] int_en;
        logic [2:0] int_st;
        logic [2:0] clr_mask;
        logic waitreq;
        logic [31:0] readdata;
        logic irq;
    } umss_state_t;
endpackage : umss_pkg

// file: src/umss_top.sv
/*
 * Modem-status and scratch register block of a serial port controller,
 * an Avalon-MM slave with waitrequest and one level interrupt.
 * Assumes modem lines arrive asynchronously and one clock at 25 MHz.
 */
// Decided for this implementation: register access over Avalon-MM.
// Operation
// - status bit 7 shows inverted carrier input
// - status bit 6 shows inverted ring input
// - status bit 4 shows inverted clear-to-send input
// - loopback: carrier bit follows aux output two
// - loopback: ring bit follows aux output one
// - loopback: clear-to-send bit follows request-to-send
// - bit 3 latches carrier change, read clears
// - loopback: carrier change watches aux output two
// - carrier held asserted over reset sets flag
// - bit 2 latches ring trailing edge, read clears
// - loopback: trailing edge on aux one falling
// - bit 0 latches clear-to-send change, read clears
// - loopback: change flag watches request-to-send
// - clear-to-send held asserted over reset sets flag
// - eight-bit scratch storage, resets zero, no side effect
`timescale 1ns/1ns
module umss_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire umss_pkg::umss_av_req_t avs_req,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // modem lines
    input wire umss_pkg::umss_modem_in_t modem_in,
    // interrupt
    output logic irq
);
    import umss_pkg::*;

    umss_state_t s;
    umss_state_t next_s;
    logic [2:0] src;
    logic [2:0] ev;
    logic req;
    logic acc;
    logic cap;
    logic [2:0] rd_clr;
    logic [2:0] int_clr;
    logic [31:0] rd_word;

    function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
        hit = (addr == target);
    endfunction : hit

    function automatic logic [31:0] status_word(input logic [2:0] lvl, input logic [2:0] fl);
        logic [31:0] w;
        w = READ_RESET;
        w[MS_CARRIER_BIT] = lvl[EV_CARRIER];
        w[MS_RING_BIT] = lvl[EV_RING];
        w[MS_CTS_BIT] = lvl[EV_CTS];
        w[MS_CARRIER_CHG_BIT] = fl[EV_CARRIER];
        w[MS_TERI_BIT] = fl[EV_RING];
        w[MS_CTS_CHG_BIT] = fl[EV_CTS];
        status_word = w;
    endfunction : status_word

    // asserted levels; in loopback the control bits replace the pins
    assign src = s.loopback ? {s.aux_output_two, s.aux_output_one, s.rts}
        : ~s.filt;

    // change on the selected source, so loopback retargets the flags too
    assign ev[EV_CARRIER] = src[EV_CARRIER] ^ s.prev[EV_CARRIER];
    assign ev[EV_RING] = s.prev[EV_RING] & ~src[EV_RING];
    assign ev[EV_CTS] = src[EV_CTS] ^ s.prev[EV_CTS];

    assign req = avs_req.read | avs_req.write;
    assign cap = req & s.waitreq;
    assign acc = req & ~s.waitreq;

    // only bits returned to software are cleared, so a later edge survives
    assign rd_clr = (acc && avs_req.read && hit(avs_req.address, MODEM_STATUS_ADDR))
        ? s.clr_mask : FLAG_RESET;
    assign int_clr = (acc && avs_req.write && avs_req.byteenable[0]
        && hit(avs_req.address, INT_CLEAR_ADDR)) ? avs_req.writedata[2:0] : INT_RESET;

    always_comb begin
        rd_word = READ_RESET;
        if (hit(avs_req.address, MODEM_STATUS_ADDR)) begin
            rd_word = status_word(src, s.flag);
        end else if (hit(avs_req.address, SPARE_STORAGE_ADDR)) begin
            rd_word[7:0] = s.spare_storage_field;
        end else if (hit(avs_req.address, MODEM_CONTROL_ADDR)) begin
            rd_word[MC_RTS_BIT] = s.rts;
            rd_word[MC_AUX_OUTPUT_ONE_BIT] = s.aux_output_one;
            rd_word[MC_AUX_OUTPUT_TWO_BIT] = s.aux_output_two;
            rd_word[MC_LOOP_BIT] = s.loopback;
        end else if (hit(avs_req.address, INT_STATUS_ADDR)) begin
            rd_word[2:0] = s.int_st;
        end else if (hit(avs_req.address, INT_ENABLE_ADDR)) begin
            rd_word[2:0] = s.int_en;
        end
    end

    always_comb begin
        next_s = s;
        // three-stage synchroniser, change taken when stages two and three agree
        next_s.sync1 = modem_in;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        for (int i = 0; i < 3; i++) begin
            if (s.sync2[i] == s.sync3[i]) begin
                next_s.filt[i] = s.sync3[i];
            end
        end
        // prev resets deasserted: a carrier or clear-to-send line held low over reset reads as a change
        next_s.prev = src;
        // set wins over clear
        next_s.flag = (s.flag & ~rd_clr) | ev;
        next_s.int_st = (s.int_st & ~int_clr) | ev;
        if (acc && avs_req.write && avs_req.byteenable[0]) begin
            if (hit(avs_req.address, SPARE_STORAGE_ADDR)) begin
                next_s.spare_storage_field = avs_req.writedata[7:0];
            end
            if (hit(avs_req.address, MODEM_CONTROL_ADDR)) begin
                next_s.rts = avs_req.writedata[MC_RTS_BIT];
                next_s.aux_output_one = avs_req.writedata[MC_AUX_OUTPUT_ONE_BIT];
                next_s.aux_output_two = avs_req.writedata[MC_AUX_OUTPUT_TWO_BIT];
                next_s.loopback = avs_req.writedata[MC_LOOP_BIT];
            end
            if (hit(avs_req.address, INT_ENABLE_ADDR)) begin
                next_s.int_en = avs_req.writedata[2:0];
            end
        end
        // fixed two-cycle handshake: capture, then answer
        if (cap) begin
            next_s.waitreq = 1'b0;
            next_s.readdata = avs_req.read ? rd_word : READ_RESET;
            next_s.clr_mask = (avs_req.read && hit(avs_req.address, MODEM_STATUS_ADDR))
                ? s.flag : FLAG_RESET;
        end
        if (acc) begin
            next_s.waitreq = 1'b1;
            next_s.clr_mask = FLAG_RESET;
        end
        next_s.irq = |(next_s.int_st & next_s.int_en);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s.sync1 <= PIN_RESET;
            s.sync2 <= PIN_RESET;
            s.sync3 <= PIN_RESET;
            s.filt <= PIN_RESET;
            s.prev <= LEVEL_RESET;
            s.flag <= FLAG_RESET;
            s.loopback <= MC_BIT_RESET;
            s.aux_output_two <= MC_BIT_RESET;
            s.aux_output_one <= MC_BIT_RESET;
            s.rts <= MC_BIT_RESET;
            s.spare_storage_field <= SPARE_RESET;
            s.int_en <= INT_RESET;
            s.int_st <= INT_RESET;
            s.clr_mask <= FLAG_RESET;
            s.waitreq <= 1'b1;
            s.readdata <= READ_RESET;
            s.irq <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign avs_readdata = s.readdata;
    assign avs_waitrequest = s.waitreq;
    assign irq = s.irq;

    // checks
    logic cap_ms;
    logic acc_ms;
    assign cap_ms = cap && avs_req.read && hit(avs_req.address, MODEM_STATUS_ADDR);
    assign acc_ms = acc && avs_req.read && hit(avs_req.address, MODEM_STATUS_ADDR);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    carrier_pin_a: assert property (
        (!s.loopback && cap_ms) |=> s.readdata[MS_CARRIER_BIT] == !$past(s.filt[EV_CARRIER]))
        else $error("carrier status not inverse of pin");
    ring_pin_a: assert property (
        (!s.loopback && cap_ms) |=> s.readdata[MS_RING_BIT] == !$past(s.filt[EV_RING]))
        else $error("ring status not inverse of pin");
    cts_pin_a: assert property (
        (!s.loopback && cap_ms) |=> s.readdata[MS_CTS_BIT] == !$past(s.filt[EV_CTS]))
        else $error("clear-to-send status not inverse of pin");
    carrier_loop_a: assert property (
        (s.loopback && cap_ms) |=> s.readdata[MS_CARRIER_BIT] == $past(s.aux_output_two))
        else $error("loopback carrier not aux output two");
    ring_loop_a: assert property (
        (s.loopback && cap_ms) |=> s.readdata[MS_RING_BIT] == $past(s.aux_output_one))
        else $error("loopback ring not aux output one");
    cts_loop_a: assert property (
        (s.loopback && cap_ms) |=> s.readdata[MS_CTS_BIT] == $past(s.rts))
        else $error("loopback clear-to-send not request-to-send");
    carrier_delta_a: assert property (
        (src[EV_CARRIER] != s.prev[EV_CARRIER]) |=> s.flag[EV_CARRIER])
        else $error("carrier change not latched");
    loop_carrier_a: assert property (
        (s.loopback && $past(s.loopback) && $changed(s.aux_output_two))
        |=> s.flag[EV_CARRIER])
        else $error("aux output two change not latched");
    ring_trail_a: assert property (
        (s.prev[EV_RING] && !src[EV_RING]) |=> s.flag[EV_RING] && s.int_st[EV_RING])
        else $error("ring trailing edge not latched");
    ring_rise_a: assert property (
        (!s.prev[EV_RING] && src[EV_RING] && !s.flag[EV_RING] && !rd_clr[EV_RING])
        |=> !s.flag[EV_RING])
        else $error("ring leading edge latched");
    cts_delta_a: assert property (
        (src[EV_CTS] != s.prev[EV_CTS]) |=> s.flag[EV_CTS])
        else $error("clear-to-send change not latched");
    flag_clear_a: assert property (
        (acc_ms && ev == FLAG_RESET) |=> (s.flag & $past(s.clr_mask)) == FLAG_RESET)
        else $error("status read did not clear flags");
    spare_write_a: assert property (
        (acc && avs_req.write && avs_req.byteenable[0]
            && hit(avs_req.address, SPARE_STORAGE_ADDR))
        |=> s.spare_storage_field == $past(avs_req.writedata[7:0]))
        else $error("scratch write lost");
    reserved_zero_a: assert property (
        acc_ms |-> s.readdata[15:8] == 8'h00 && !s.readdata[5] && !s.readdata[1])
        else $error("reserved status bit not zero");
    ack_pulse_a: assert property (
        cap |=> !s.waitreq ##1 s.waitreq)
        else $error("answer not exactly one cycle");
    irq_level_a: assert property (
        s.irq == |(s.int_st & s.int_en))
        else $error("interrupt level mismatch");

    // level source selection
    pin_levels_a: assert property (
        !s.loopback |-> src[EV_CARRIER] == !s.filt[EV_CARRIER])
        else $error("carrier level not inverse of filtered pin");
    ring_level_a: assert property (
        !s.loopback |-> src[EV_RING] == !s.filt[EV_RING])
        else $error("ring level not inverse of filtered pin");
    cts_level_a: assert property (
        !s.loopback |-> src[EV_CTS] == !s.filt[EV_CTS])
        else $error("clear-to-send level not inverse of filtered pin");
    carrier_src_a: assert property (
        s.loopback |-> src[EV_CARRIER] == s.aux_output_two)
        else $error("loopback carrier source wrong");
    ring_src_a: assert property (
        s.loopback |-> src[EV_RING] == s.aux_output_one)
        else $error("loopback ring source wrong");
    cts_src_a: assert property (
        s.loopback |-> src[EV_CTS] == s.rts)
        else $error("loopback clear-to-send source wrong");

    // synchroniser: a one-cycle glitch on a pin must never reach filt
    sync_chain_a: assert property (
        !$past(rst) |-> s.sync3 == $past(s.sync2) && s.sync2 == $past(s.sync1))
        else $error("synchroniser stages not chained");
    sync_take_a: assert property (
        (s.sync2 == s.sync3) |=> s.filt == $past(s.sync3))
        else $error("agreed pin level not taken");
    sync_hold_a: assert property (
        ((s.filt ^ $past(s.filt)) & $past(s.sync2 ^ s.sync3)) == 3'h0)
        else $error("filtered level moved without agreement");

    // change flags
    prev_reset_a: assert property (
        $past(rst) |-> s.prev == LEVEL_RESET)
        else $error("previous level not deasserted after reset");
    prev_track_a: assert property (
        !$past(rst) |-> s.prev == $past(src))
        else $error("previous level not tracking source");
    flag_reset_a: assert property (
        $past(rst) |-> s.flag == FLAG_RESET && s.int_st == INT_RESET)
        else $error("flags not clear after reset");
    flag_hold_a: assert property (
        (ev == FLAG_RESET && rd_clr == FLAG_RESET) |=> s.flag == $past(s.flag))
        else $error("flag moved without event or read");
    flag_sticky_a: assert property (
        ev != FLAG_RESET |=> (s.flag & $past(ev)) == $past(ev))
        else $error("event lost against clear");
    mask_take_a: assert property (
        cap_ms |=> s.clr_mask == $past(s.flag))
        else $error("clear mask not the flags shown");
    mask_idle_a: assert property (
        s.waitreq |-> s.clr_mask == FLAG_RESET)
        else $error("clear mask left armed");
    status_wr_a: assert property (
        (acc && avs_req.write && hit(avs_req.address, MODEM_STATUS_ADDR))
        |=> s.flag == ($past(s.flag) | $past(ev)))
        else $error("status write disturbed flags");
    loop_ring_a: assert property (
        (s.loopback && $past(s.loopback) && $fell(s.aux_output_one))
        |=> s.flag[EV_RING])
        else $error("aux output one fall not latched");
    loop_rise_a: assert property (
        (s.loopback && $past(s.loopback) && $rose(s.aux_output_one) && !s.flag[EV_RING])
        |=> !s.flag[EV_RING])
        else $error("aux output one rise latched");
    loop_cts_a: assert property (
        (s.loopback && $past(s.loopback) && $changed(s.rts))
        |=> s.flag[EV_CTS])
        else $error("request-to-send change not latched");
    // in loopback the pins may toggle freely and must stay unseen
    carrier_quiet_a: assert property (
        (s.loopback && $past(s.loopback) && $stable(s.aux_output_two))
        |-> !ev[EV_CARRIER])
        else $error("carrier change without aux output two change");
    cts_quiet_a: assert property (
        (s.loopback && $past(s.loopback) && $stable(s.rts))
        |-> !ev[EV_CTS])
        else $error("clear-to-send change without request-to-send change");

    // interrupt registers
    int_set_a: assert property (
        ev != FLAG_RESET |=> (s.int_st & $past(ev)) == $past(ev))
        else $error("interrupt status missed event");
    int_clear_a: assert property (
        (int_clr != INT_RESET && ev == FLAG_RESET)
        |=> (s.int_st & $past(int_clr)) == INT_RESET)
        else $error("interrupt clear ignored");
    int_hold_a: assert property (
        (ev == FLAG_RESET && int_clr == INT_RESET) |=> s.int_st == $past(s.int_st))
        else $error("interrupt status moved on its own");
    int_en_wr_a: assert property (
        (acc && avs_req.write && avs_req.byteenable[0]
            && hit(avs_req.address, INT_ENABLE_ADDR))
        |=> s.int_en == $past(avs_req.writedata[2:0]))
        else $error("interrupt enable write lost");

    // register bus
    reset_out_a: assert property (
        $past(rst) |-> s.waitreq && s.readdata == READ_RESET && !s.irq)
        else $error("outputs not at reset values");
    wait_idle_a: assert property (
        !req |-> s.waitreq)
        else $error("answer without request");
    rdata_hold_a: assert property (
        !cap |=> s.readdata == $past(s.readdata))
        else $error("read data moved outside capture");
    write_zero_a: assert property (
        (cap && avs_req.write) |=> s.readdata == READ_RESET)
        else $error("read data not zero on write");
    mcr_write_a: assert property (
        (acc && avs_req.write && avs_req.byteenable[0]
            && hit(avs_req.address, MODEM_CONTROL_ADDR))
        |=> s.loopback == $past(avs_req.writedata[MC_LOOP_BIT])
            && s.rts == $past(avs_req.writedata[MC_RTS_BIT]))
        else $error("modem control write lost");
    be_skip_a: assert property (
        (acc && avs_req.write && !avs_req.byteenable[0])
        |=> s.spare_storage_field == $past(s.spare_storage_field)
            && s.int_en == $past(s.int_en))
        else $error("write without lane zero took effect");
    spare_keep_a: assert property (
        !(acc && avs_req.write && avs_req.byteenable[0]
            && hit(avs_req.address, SPARE_STORAGE_ADDR))
        |=> s.spare_storage_field == $past(s.spare_storage_field))
        else $error("scratch changed without write");
    spare_read_a: assert property (
        (cap && avs_req.read && hit(avs_req.address, SPARE_STORAGE_ADDR))
        |=> s.readdata == {24'h000000, $past(s.spare_storage_field)})
        else $error("scratch read data wrong");
endmodule : umss_top

// file: verif/umss_modem_model.sv
/*
 * Modem partner: drives the three active-low modem lines.
 * Assumes the bench names the wanted levels and a lag in clock cycles.
 */
`timescale 1ns/1ns
module umss_modem_model (
    // clock
    input wire logic clk,
    // wanted levels and lag
    input wire umss_pkg::umss_modem_in_t want,
    input wire logic [3:0] lag,
    // lines to the device
    output umss_pkg::umss_modem_in_t lines
);
    import umss_pkg::*;
    int cnt = 0;
    initial lines = PIN_RESET;
    // lag lets the modem answer promptly or slowly
    always @(posedge clk) begin
        if (want === lines) begin
            cnt <= 0;
        end else if (cnt >= lag) begin
            lines <= want;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : umss_modem_model

// file: verif/umss_top_tb.sv
/*
 * Self-checking bench of the modem-status and scratch block.
 * Assumes the Avalon timing and interrupt layout of the design package.
 */
`timescale 1ns/1ns
module umss_top_tb;
    import umss_pkg::*;
    logic clk = 0;
    logic rst = 1;
    umss_av_req_t req = '0;
    logic [31:0] rdata;
    logic wreq;
    logic irq;
    umss_modem_in_t want = 3'h2;
    umss_modem_in_t pins;
    logic [3:0] lag = 4'h0;
    int err_total = 0;
    int comparisons = 0;
    // asserted levels and expected flags, event index order
    logic [2:0] eff = 3'h0, flg = 3'h0, ist = 3'h0, ien = 3'h0;
    logic [4:0] modem_control_register = 5'h00;
    logic [7:0] spare = 8'h00;
    logic [31:0] d, v;
    always #20 clk = ~clk;
    umss_top umss_top_i(.clk(clk), .rst(rst), .avs_req(req), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .modem_in(pins), .irq(irq));
    umss_modem_model umss_modem_model_i(.clk(clk), .want(want), .lag(lag), .lines(pins));

    task give_verdict;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // one transfer; request held until waitrequest is seen low
    task bus(input logic w, input logic [31:0] a, input logic [31:0] wd, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{read: !w, write: w, address: a, writedata: wd, byteenable: be};
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 40);
        if (n >= 40) begin
            err_total++;
            give_verdict;
        end
        d = rdata;
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask : bus

    // new asserted levels: any change of carrier/cts, falling ring level
    task upd(input logic [2:0] nw);
        logic [2:0] ev;
        ev = ((nw ^ eff) & 3'h5) | (eff & ~nw & 3'h2);
        flg |= ev;
        ist |= ev;
        eff = nw;
    endtask : upd

    function automatic logic [31:0] exp_ms();
        return {24'h0, eff[EV_CARRIER], eff[EV_RING], 1'b0, eff[EV_CTS],
            flg[EV_CARRIER], flg[EV_RING], 1'b0, flg[EV_CTS]};
    endfunction : exp_ms

    task rd_status;
        bus(1'b0, MODEM_STATUS_ADDR, 32'h0, 4'hF);
        chk("modem_status", exp_ms(), d);
        flg = 3'h0;
    endtask : rd_status

    initial begin
        d = $urandom(188);
        repeat (10) @(posedge clk);
        chk("irq_in_reset", 32'h0, {31'h0, irq});
        rst <= 1'b0;
        upd(~want);
        repeat (8) @(posedge clk);
        rd_status;
        rd_status;
        bus(1'b0, SPARE_STORAGE_ADDR, 32'h0, 4'hF);
        chk("spare_reset", 32'h0, d);
        for (int i = 0; i < 40; i++) begin
            v = $urandom;
            @(posedge clk);
            lag <= 4'(v[7:4]);
            want <= 3'(v[2:0]);
            upd(modem_control_register[4] ? modem_control_register[3:1] : ~v[2:0]);
            repeat (24) @(posedge clk);
            // status writes must not disturb anything
            bus(1'b1, MODEM_STATUS_ADDR, $urandom, 4'hF);
            v = $urandom;
            bus(1'b1, MODEM_CONTROL_ADDR, v, 4'h1);
            modem_control_register = {v[4:1], 1'b0};
            // leaving loopback hands the levels back to the pins
            upd(modem_control_register[4] ? modem_control_register[3:1] : ~want);
            bus(1'b0, MODEM_CONTROL_ADDR, 32'h0, 4'hF);
            chk("modem_control", {27'h0, modem_control_register}, d);
            repeat (6) @(posedge clk);
            rd_status;
            v = $urandom;
            bus(1'b1, SPARE_STORAGE_ADDR, v, {3'h0, v[9]});
            if (v[9]) spare = v[7:0];
            bus(1'b0, SPARE_STORAGE_ADDR, 32'h0, 4'hF);
            chk("spare_storage", {24'h0, spare}, d);
            bus(1'b0, 32'h50001020, 32'h0, 4'hF);
            chk("unmapped", 32'h0, d);
            v = $urandom;
            ien = v[2:0];
            bus(1'b1, INT_ENABLE_ADDR, {29'h0, ien}, 4'hF);
            repeat (2) @(posedge clk);
            chk("irq", {31'h0, |(ist & ien)}, {31'h0, irq});
            bus(1'b0, INT_STATUS_ADDR, 32'h0, 4'hF);
            chk("int_status", {29'h0, ist}, d);
            bus(1'b1, INT_CLEAR_ADDR, {29'h0, v[6:4]}, 4'hF);
            ist &= ~v[6:4];
            bus(1'b0, INT_STATUS_ADDR, 32'h0, 4'hF);
            chk("int_cleared", {29'h0, ist}, d);
        end
        give_verdict;
    end
endmodule : umss_top_tb
